// file: pcfg_cfg.svh
// Addresses, reset values and field codes of the port 0 pin configuration block.
// Assumes an 8-bit register address space in which the two registers sit side by side.
`ifndef PCFG_CFG_SVH
`define PCFG_CFG_SVH

`define PCFG_ADDR_CONFIG_LOW 8'hE1
`define PCFG_ADDR_PULLUP     8'hE2
`define PCFG_RESET_VAL       8'h00
`define PCFG_READ_IDLE       8'h00
`define PCFG_LOW_PINS        4
`define PCFG_ALL_PINS        8
`define PCFG_FIELD_W         2
`define PCFG_CODE_SCHMITT    2'h0
`define PCFG_CODE_ALT2       2'h1
`define PCFG_CODE_ANALOG     2'h2
`define PCFG_CODE_PUSHPULL   2'h3
`define PCFG_ALT2_PIN        0

`endif

// file: pcfg_pkg.sv
// Types shared by the port 0 pin configuration block.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package pcfg_pkg;
   // Decoded mode of one lower pin
   typedef enum logic [2:0] {
      PCFG_MODE_SCHMITT,
      PCFG_MODE_UNUSED,
      PCFG_MODE_ALT_ANALOG,
      PCFG_MODE_ALT_SECOND,
      PCFG_MODE_PUSH_PULL
   } pcfg_mode_t;

   // Per-pin controls handed to the pad
   typedef struct packed {
      logic drive_en;
      logic analog_sel;
      logic alt2_sel;
      logic schmitt_en;
   } pcfg_pin_ctl_t;
endpackage
`default_nettype wire

// file: pcfg_port0.sv
// Port 0 lower-pin configuration and pull-up control.
// Assumes a single 25 MHz clock, synchronous active-low reset and a master that never overlaps strobes.
// Contract
// - A read-write 8-bit low configuration register holds one 2-bit field per lower pin and resets to zero.
// - Each field decodes 00 to Schmitt input, 10 to analog alternative function and 11 to push-pull output.
// - A read-write 8-bit pull-up enable register has one bit per pin, 1 enabling, and resets to zero.
// - A pin in push-pull output or an alternative function has its pull-up forced off; pull-ups of upper pins 4 to 7 follow their enable bits alone.
//
// The strobed register port was chosen for this implementation.
`include "pcfg_cfg.svh"
`default_nettype none
module pcfg_port0 (
   input  wire logic                              clk_in,
   input  wire logic                              rst_n_in,
   input  wire logic [7:0]                        addr_in,
   input  wire logic [7:0]                        wdata_in,
   input  wire logic                              wr_in,
   input  wire logic                              rd_in,
   output var  logic [7:0]                        rdata_out,
   output var  pcfg_pkg::pcfg_pin_ctl_t [3:0]     pin_ctl_out,
   output var  logic [7:0]                        pullup_out
);

   logic [7:0]                    cfg_ff;
   logic [7:0]                    nxt_cfg;
   logic [7:0]                    pu_ff;
   logic [7:0]                    nxt_pu;
   logic [7:0]                    nxt_rdata;
   logic [7:0]                    nxt_pullup;
   pcfg_pkg::pcfg_pin_ctl_t [3:0] nxt_pin_ctl;
   pcfg_pkg::pcfg_mode_t [3:0]    pin_mode;
   logic [3:0]                    pu_block;

   // Register file
   always_comb begin
      nxt_cfg   = cfg_ff;
      nxt_pu    = pu_ff;
      nxt_rdata = `PCFG_READ_IDLE;
      if (wr_in) begin
         if (addr_in == `PCFG_ADDR_CONFIG_LOW) begin
            nxt_cfg = wdata_in;
         end
         if (addr_in == `PCFG_ADDR_PULLUP) begin
            nxt_pu = wdata_in;
         end
      end
      if (rd_in) begin
         case (addr_in)
            `PCFG_ADDR_CONFIG_LOW: nxt_rdata = cfg_ff;
            `PCFG_ADDR_PULLUP:     nxt_rdata = pu_ff;
            default:               nxt_rdata = `PCFG_READ_IDLE;
         endcase
      end
   end

   // Decode works on the next values so pad controls move on the same edge as the register
   genvar g;
   generate
      for (g = 0; g < `PCFG_LOW_PINS; g++) begin : g_pin
         always_comb begin
            case (nxt_cfg[`PCFG_FIELD_W*g+`PCFG_FIELD_W-1 -: `PCFG_FIELD_W])
               `PCFG_CODE_SCHMITT:  pin_mode[g] = pcfg_pkg::PCFG_MODE_SCHMITT;
               `PCFG_CODE_ANALOG:   pin_mode[g] = pcfg_pkg::PCFG_MODE_ALT_ANALOG;
               `PCFG_CODE_PUSHPULL: pin_mode[g] = pcfg_pkg::PCFG_MODE_PUSH_PULL;
               `PCFG_CODE_ALT2: begin
                  // Only pin 0 has a second function; elsewhere the code acts as Schmitt input
                  if (g == `PCFG_ALT2_PIN) begin
                     pin_mode[g] = pcfg_pkg::PCFG_MODE_ALT_SECOND;
                  end else begin
                     pin_mode[g] = pcfg_pkg::PCFG_MODE_UNUSED;
                  end
               end
               default:             pin_mode[g] = pcfg_pkg::PCFG_MODE_SCHMITT;
            endcase
            nxt_pin_ctl[g].drive_en   = (pin_mode[g] == pcfg_pkg::PCFG_MODE_PUSH_PULL);
            nxt_pin_ctl[g].analog_sel = (pin_mode[g] == pcfg_pkg::PCFG_MODE_ALT_ANALOG);
            nxt_pin_ctl[g].alt2_sel   = (pin_mode[g] == pcfg_pkg::PCFG_MODE_ALT_SECOND);
            nxt_pin_ctl[g].schmitt_en = (pin_mode[g] == pcfg_pkg::PCFG_MODE_SCHMITT) ||
                                        (pin_mode[g] == pcfg_pkg::PCFG_MODE_UNUSED);
            pu_block[g] = nxt_pin_ctl[g].drive_en || nxt_pin_ctl[g].analog_sel ||
                          nxt_pin_ctl[g].alt2_sel;
            nxt_pullup[g] = nxt_pu[g] && !pu_block[g];
         end
      end
      // Upper pins are configured elsewhere; their pull-ups follow the enable bits alone
      for (g = `PCFG_LOW_PINS; g < `PCFG_ALL_PINS; g++) begin : g_upper
         always_comb begin
            nxt_pullup[g] = nxt_pu[g];
         end
      end
   endgenerate

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         cfg_ff      <= `PCFG_RESET_VAL;
         pu_ff       <= `PCFG_RESET_VAL;
         rdata_out   <= `PCFG_READ_IDLE;
         pullup_out  <= `PCFG_RESET_VAL;
         pin_ctl_out <= '0;
      end else begin
         cfg_ff      <= nxt_cfg;
         pu_ff       <= nxt_pu;
         rdata_out   <= nxt_rdata;
         pullup_out  <= nxt_pullup;
         pin_ctl_out <= nxt_pin_ctl;
      end
   end

   // Checks
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);

   sequence s_cfg_write;
      wr_in && addr_in == `PCFG_ADDR_CONFIG_LOW;
   endsequence

   sequence s_pu_write;
      wr_in && addr_in == `PCFG_ADDR_PULLUP;
   endsequence

   property p_cfg_write_read;
      logic [7:0] v;
      (s_cfg_write, v = wdata_in) ##1 (rd_in && addr_in == `PCFG_ADDR_CONFIG_LOW && !wr_in)
         |=> rdata_out == v;
   endproperty
   a_cfg_write_read: assert property (p_cfg_write_read)
      else $error("Config register did not read back written value");

   property p_pu_write_read;
      logic [7:0] v;
      (s_pu_write, v = wdata_in) ##1 (rd_in && addr_in == `PCFG_ADDR_PULLUP && !wr_in)
         |=> rdata_out == v;
   endproperty
   a_pu_write_read: assert property (p_pu_write_read)
      else $error("Pull-up register did not read back written value");

   property p_read_idle;
      !rd_in |=> rdata_out == `PCFG_READ_IDLE;
   endproperty
   a_read_idle: assert property (p_read_idle)
      else $error("Read data not idle without a read strobe");

   property p_pushpull_drive;
      s_cfg_write ##0 wdata_in[7:6] == `PCFG_CODE_PUSHPULL
         |=> pin_ctl_out[3].drive_en && !pin_ctl_out[3].analog_sel;
   endproperty
   a_pushpull_drive: assert property (p_pushpull_drive)
      else $error("Push-pull code did not enable pin 3 drive");

   property p_analog_sel;
      s_cfg_write ##0 wdata_in[5:4] == `PCFG_CODE_ANALOG
         |=> pin_ctl_out[2].analog_sel && !pin_ctl_out[2].drive_en;
   endproperty
   a_analog_sel: assert property (p_analog_sel)
      else $error("Analog code did not select pin 2 analog function");

   property p_pullup_forced;
      cfg_ff[1] && pu_ff[3:0] == 4'hF |-> !pullup_out[0];
   endproperty
   a_pullup_forced: assert property (p_pullup_forced)
      else $error("Pull-up on pin 0 not forced off");

   property p_pullup_follows;
      !cfg_ff[7] |-> pullup_out[3] == pu_ff[3];
   endproperty
   a_pullup_follows: assert property (p_pullup_follows)
      else $error("Pull-up on pin 3 does not follow its enable bit");

   property p_alt2_pin0;
      cfg_ff[1:0] == `PCFG_CODE_ALT2 |-> pin_ctl_out[0].alt2_sel && !pullup_out[0];
   endproperty
   a_alt2_pin0: assert property (p_alt2_pin0)
      else $error("Pin 0 second function not selected or pull-up left on");

   // Bus checks
   sequence s_other_write;
      wr_in && addr_in != `PCFG_ADDR_CONFIG_LOW && addr_in != `PCFG_ADDR_PULLUP;
   endsequence

   sequence s_other_read;
      rd_in && addr_in != `PCFG_ADDR_CONFIG_LOW && addr_in != `PCFG_ADDR_PULLUP;
   endsequence

   sequence s_cfg_read;
      rd_in && addr_in == `PCFG_ADDR_CONFIG_LOW && !wr_in;
   endsequence

   sequence s_pu_read;
      rd_in && addr_in == `PCFG_ADDR_PULLUP && !wr_in;
   endsequence

   // Must look at the cycles under reset, so the default disable is overridden
   property p_reset_clear;
      disable iff (1'b0)
      !rst_n_in |=> cfg_ff == `PCFG_RESET_VAL && pu_ff == `PCFG_RESET_VAL &&
         pullup_out == `PCFG_RESET_VAL && rdata_out == `PCFG_READ_IDLE;
   endproperty
   a_reset_clear: assert property (p_reset_clear)
      else $error("Registers not cleared by reset");

   property p_cfg_hold;
      !(wr_in && addr_in == `PCFG_ADDR_CONFIG_LOW) |=> $stable(cfg_ff);
   endproperty
   a_cfg_hold: assert property (p_cfg_hold)
      else $error("Config register changed without a write");

   property p_pu_hold;
      !(wr_in && addr_in == `PCFG_ADDR_PULLUP) |=> $stable(pu_ff);
   endproperty
   a_pu_hold: assert property (p_pu_hold)
      else $error("Pull-up register changed without a write");

   property p_refused_write;
      s_other_write |=> $stable(cfg_ff) && $stable(pu_ff);
   endproperty
   a_refused_write: assert property (p_refused_write)
      else $error("Write to a foreign address changed a register");

   property p_refused_read;
      s_other_read |=> rdata_out == `PCFG_READ_IDLE;
   endproperty
   a_refused_read: assert property (p_refused_read)
      else $error("Read of a foreign address returned data");

   property p_cfg_read_value;
      s_cfg_read |=> rdata_out == $past(cfg_ff);
   endproperty
   a_cfg_read_value: assert property (p_cfg_read_value)
      else $error("Config read did not return the stored value");

   property p_pu_read_value;
      s_pu_read |=> rdata_out == $past(pu_ff);
   endproperty
   a_pu_read_value: assert property (p_pu_read_value)
      else $error("Pull-up read did not return the stored value");

   property p_upper_follow;
      logic [7:0] v;
      (s_pu_write, v = wdata_in) |=> pullup_out[7:4] == v[7:4];
   endproperty
   a_upper_follow: assert property (p_upper_follow)
      else $error("Upper pull-ups do not follow their enable bits");

   // Pad checks
   property p_pullup_hold;
      !wr_in |=> $stable(pullup_out);
   endproperty
   a_pullup_hold: assert property (p_pullup_hold)
      else $error("Pull-up outputs moved without a write");

   // Outputs are decoded one edge after release, hence the sampled reset as trigger
   property p_one_mode;
      rst_n_in |=> $onehot(pin_ctl_out[0]) && $onehot(pin_ctl_out[1]) &&
         $onehot(pin_ctl_out[2]) && $onehot(pin_ctl_out[3]);
   endproperty
   a_one_mode: assert property (p_one_mode)
      else $error("A lower pin is not in exactly one mode");

   property p_alt2_only_pin0;
      !pin_ctl_out[1].alt2_sel && !pin_ctl_out[2].alt2_sel &&
         !pin_ctl_out[3].alt2_sel;
   endproperty
   a_alt2_only_pin0: assert property (p_alt2_only_pin0)
      else $error("Second function selected on a pin other than pin 0");

   property p_unused_input;
      s_cfg_write ##0 wdata_in[3:2] == `PCFG_CODE_ALT2
         |=> pin_ctl_out[1].schmitt_en;
   endproperty
   a_unused_input: assert property (p_unused_input)
      else $error("Unused code on pin 1 did not leave it a Schmitt input");

   property p_alt2_write;
      s_cfg_write ##0 wdata_in[1:0] == `PCFG_CODE_ALT2
         |=> pin_ctl_out[0].alt2_sel && !pullup_out[0];
   endproperty
   a_alt2_write: assert property (p_alt2_write)
      else $error("Second function code on pin 0 not applied");

   property p_pushpull_pin0;
      s_cfg_write ##0 wdata_in[1:0] == `PCFG_CODE_PUSHPULL
         |=> pin_ctl_out[0].drive_en && !pullup_out[0];
   endproperty
   a_pushpull_pin0: assert property (p_pushpull_pin0)
      else $error("Push-pull on pin 0 left its pull-up on");

   property p_analog_pin1;
      s_cfg_write ##0 wdata_in[3:2] == `PCFG_CODE_ANALOG
         |=> pin_ctl_out[1].analog_sel && !pullup_out[1];
   endproperty
   a_analog_pin1: assert property (p_analog_pin1)
      else $error("Analog function on pin 1 left its pull-up on");

   property p_forced_off;
      !((pin_ctl_out[0].drive_en || pin_ctl_out[0].analog_sel) && pullup_out[0]) &&
      !((pin_ctl_out[1].drive_en || pin_ctl_out[1].analog_sel) && pullup_out[1]) &&
      !((pin_ctl_out[2].drive_en || pin_ctl_out[2].analog_sel) && pullup_out[2]) &&
      !((pin_ctl_out[3].drive_en || pin_ctl_out[3].analog_sel) && pullup_out[3]);
   endproperty
   a_forced_off: assert property (p_forced_off)
      else $error("Pull-up on while a lower pin drives or is analog");

   property p_schmitt_follow;
      pin_ctl_out[2].schmitt_en |-> pullup_out[2] == pu_ff[2];
   endproperty
   a_schmitt_follow: assert property (p_schmitt_follow)
      else $error("Pull-up on Schmitt input pin 2 does not follow its bit");

endmodule
`default_nettype wire

// file: pcfg_tb.sv
// Self-checking bench for the port 0 pin configuration block, with an integer model.
// Assumes pcfg_pkg and pcfg_port0 are compiled first; the bench drives the register port.
`include "pcfg_cfg.svh"
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic                          clk_in = 1'b0;
   logic                          rst_n_in = 1'b0;
   logic [7:0]                    addr_in = 8'h00;
   logic [7:0]                    wdata_in = 8'h00;
   logic                          wr_in = 1'b0;
   logic                          rd_in = 1'b0;
   logic [7:0]                    rdata_out;
   pcfg_pkg::pcfg_pin_ctl_t [3:0] pin_ctl_out;
   logic [7:0]                    pullup_out;
   int                            err_total = 0;
   int                            tests_run = 0;
   int                            cfg_m = 0;
   int                            pu_m = 0;
   int                            v;
   always #20 clk_in = ~clk_in;
   pcfg_port0 dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
      .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
      .pin_ctl_out(pin_ctl_out), .pullup_out(pullup_out));
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   function automatic logic [15:0] exp_ctl();
      logic [15:0] r;
      int          c;
      r = 16'h0000;
      for (int p = 0; p < 4; p++) begin
         c = (cfg_m >> (2 * p)) & 3;
         if (c == 3) r[4*p+3] = 1'b1;
         else if (c == 2) r[4*p+2] = 1'b1;
         else if (c == 1 && p == 0) r[1] = 1'b1;
         else r[4*p] = 1'b1;
      end
      return r;
   endfunction
   function automatic logic [7:0] exp_pu();
      int m;
      m = pu_m;
      for (int p = 0; p < 4; p++) begin
         if (((cfg_m >> (2 * p)) & 3) >= 2 || (p == 0 && (cfg_m & 3) == 1)) m &= ~(1 << p);
      end
      return m[7:0];
   endfunction
   function automatic logic [7:0] exp_rd(input logic [7:0] a);
      if (a == `PCFG_ADDR_CONFIG_LOW) return 8'(cfg_m);
      if (a == `PCFG_ADDR_PULLUP) return 8'(pu_m);
      return `PCFG_READ_IDLE;
   endfunction
   task automatic check_outs();
      @(negedge clk_in);
      chk(16'(pin_ctl_out), exp_ctl());
      chk({8'h00, pullup_out}, {8'h00, exp_pu()});
      chk({8'h00, rdata_out}, 16'h0000);
   endtask
   // Waits for an edge first, so a strobe just dropped is never raised again in one step
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge clk_in);
      wr_in <= 1'b0;
      if (a == `PCFG_ADDR_CONFIG_LOW) cfg_m = d;
      if (a == `PCFG_ADDR_PULLUP) pu_m = d;
   endtask
   // Called right after a rising edge; read data stand one cycle only, so they are taken then
   task automatic rd_now(input logic [7:0] a);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge clk_in);
      rd_in <= 1'b0;
      @(negedge clk_in);
      chk({8'h00, rdata_out}, {8'h00, exp_rd(a)});
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clk_in);
      rd_now(a);
   endtask
   task automatic conclude();
      $display("Checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial begin
      v = $urandom(32'h55EA93AE);
      repeat (15) @(posedge clk_in);
      @(negedge clk_in);
      chk({pullup_out, rdata_out}, 16'h0000);
      chk(16'(pin_ctl_out), 16'h0000);
      @(posedge clk_in);
      rst_n_in <= 1'b1;
      // Pad controls are decoded only at the first edge that sees reset released
      @(posedge clk_in);
      check_outs();
      rd(`PCFG_ADDR_CONFIG_LOW);
      rd(`PCFG_ADDR_PULLUP);
      wr(`PCFG_ADDR_PULLUP, 8'hFF);
      rd_now(`PCFG_ADDR_PULLUP);
      for (int c = 0; c < 4; c++) begin
         wr(`PCFG_ADDR_CONFIG_LOW, {4{2'(c)}});
         rd_now(`PCFG_ADDR_CONFIG_LOW);
         check_outs();
      end
      wr(8'hE0, 8'h00);
      check_outs();
      wr(8'hE3, 8'h00);
      rd(8'hE3);
      rd(8'hE0);
      check_outs();
      repeat (60) begin
         v = $urandom;
         wr(v[8] ? `PCFG_ADDR_PULLUP : `PCFG_ADDR_CONFIG_LOW, v[7:0]);
         if (v[10]) @(posedge clk_in);
         rd_now(v[9] ? `PCFG_ADDR_PULLUP : `PCFG_ADDR_CONFIG_LOW);
         check_outs();
      end
      @(posedge clk_in);
      rst_n_in <= 1'b0;
      repeat (2) @(posedge clk_in);
      rst_n_in <= 1'b1;
      cfg_m = 0;
      pu_m = 0;
      @(posedge clk_in);
      check_outs();
      rd(`PCFG_ADDR_PULLUP);
      rd(`PCFG_ADDR_CONFIG_LOW);
      conclude();
   end
   // The tests need some 330 cycles; about six times that means a hang
   initial begin
      #(40 * 2000);
      err_total++;
      conclude();
   end
endmodule
`default_nettype wire
